// ### common/pcics_if.sv
// pcics_if: enable bits handed from the register core to the gates.
// assumes all members are driven in the REF_CLK domain.
`timescale 1ns/1ns
interface pcics_if;
    logic [4:0] cmd; // live command enables
    modport ctl (output cmd);
    modport gate (input cmd);
endinterface : pcics_if

// ### common/pcics_pkg.sv
// pcics_pkg: offsets, field positions, reset values and codes for the
// pci configuration command/status block.
// assumes a single 250 MHz clock domain and word-wide register port.
package pcics_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] CMD_IDX = 8'h04; // command register
    localparam logic [7:0] STS_IDX = 8'h06; // status register
    localparam logic [7:0] IRQ_STAT_IDX = 8'h40; // sticky event status
    localparam logic [7:0] IRQ_MASK_IDX = 8'h41; // event mask
    localparam logic [7:0] CAP_PTR_IDX = 8'h34; // capability pointer
    localparam logic [9:0] CMD_ADDR = 10'h010;
    localparam logic [9:0] STS_ADDR = 10'h018;
    localparam logic [9:0] CAP_ADDR = 10'h0D0;
    localparam logic [9:0] IRQ_STAT_ADDR = 10'h100;
    localparam logic [9:0] IRQ_MASK_ADDR = 10'h104;
    // command bit positions
    localparam int CMD_IO_BIT = 0;
    localparam int CMD_MEM_BIT = 1;
    localparam int CMD_BM_BIT = 2;
    localparam int CMD_SPC_BIT = 3;
    localparam int CMD_MWI_BIT = 4;
    localparam logic [4:0] CMD_RESET = 5'h00;
    localparam logic [4:0] CMD_WMASK = 5'h1F;
    // status bit positions
    localparam int STS_CAP_BIT = 4;
    localparam int STS_DEVSEL_LSB = 9;
    localparam logic [1:0] DEVSEL_FAST = 2'h0;
    localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
    localparam logic [1:0] DEVSEL_SLOW = 2'h2;
    localparam logic [15:0] STS_RESET = 16'h0210;
    localparam logic [7:0] CAP_PTR_VALUE = 8'h40; // arbitrary list start
    // event bits
    localparam int EV_SPC_BIT = 0;
    localparam int EV_MEM_BIT = 1;
    localparam int EV_IO_BIT = 2;
    localparam int EV_MWI_BIT = 3;
    localparam int EV_W = 4;
    // master command codes
    localparam logic [3:0] PCI_MEM_WRITE = 4'h7;
    localparam logic [3:0] PCI_MEM_WRITE_INV = 4'hF;
    typedef enum logic [1:0] {
        PCICS_IDLE = 2'b00,
        PCICS_REQ = 2'b01,
        PCICS_OWN = 2'b10
    } pcics_mst_type;
endpackage : pcics_pkg

// ### core/pcics_event.sv
// pcics_event: one sticky write-one-to-clear event bit.
// assumes a synchronous clear strobe and a one-cycle set pulse.
`timescale 1ns/1ns
module pcics_event (
    input wire logic clk,
    input wire logic nrst,
    input wire logic set,
    input wire logic clr,
    output logic flag
);
    typedef struct packed { logic f; } pcics_ev_type;
    pcics_ev_type st_r, st_nxt;
    // set wins over clear so an event in the clearing cycle survives
    always_comb begin
        st_nxt = st_r;
        if (clr) st_nxt.f = 1'b0;
        if (set) st_nxt.f = 1'b1;
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) st_r <= '0;
        else st_r <= st_nxt;
    end
    assign flag = st_r.f;
    set_wins_a: assert property (@(posedge clk) disable iff (!nrst) set |=> flag)
        else $error("event lost");
endmodule : pcics_event

// ### core/pcics_gate.sv
// pcics_gate: qualifies target claims, special cycles and master commands.
// assumes requests are level inputs sampled each REF_CLK edge.
`timescale 1ns/1ns
module pcics_gate (
    input wire logic clk,
    input wire logic nrst,
    pcics_if.gate en,
    input wire logic mem_hit,
    input wire logic io_hit,
    input wire logic spc_seen,
    input wire logic wr_want,
    input wire logic wr_inv_want,
    output logic mem_claim,
    output logic io_claim,
    output logic spc_take,
    output logic [3:0] wr_cmd
);
    // pure qualification; registered by the top
    always_comb begin
        mem_claim = mem_hit & en.cmd[pcics_pkg::CMD_MEM_BIT];
        io_claim = io_hit & en.cmd[pcics_pkg::CMD_IO_BIT];
        spc_take = spc_seen & en.cmd[pcics_pkg::CMD_SPC_BIT];
        // invalidate form only when enabled, else plain write
        wr_cmd = (wr_inv_want & en.cmd[pcics_pkg::CMD_MWI_BIT]) ? pcics_pkg::PCI_MEM_WRITE_INV
                 : pcics_pkg::PCI_MEM_WRITE;
    end
    mwi_gated_a: assert property (@(posedge clk) disable iff (!nrst)
        !en.cmd[pcics_pkg::CMD_MWI_BIT] |-> wr_cmd == pcics_pkg::PCI_MEM_WRITE)
        else $error("invalidate issued while disabled");
    mem_gated_a: assert property (@(posedge clk) disable iff (!nrst)
        mem_claim |-> en.cmd[pcics_pkg::CMD_MEM_BIT])
        else $error("memory claim while disabled");
    io_gated_a: assert property (@(posedge clk) disable iff (!nrst)
        io_claim |-> en.cmd[pcics_pkg::CMD_IO_BIT])
        else $error("io claim while disabled");
    spc_gated_a: assert property (@(posedge clk) disable iff (!nrst)
        spc_take |-> en.cmd[pcics_pkg::CMD_SPC_BIT])
        else $error("special cycle taken while disabled");
    wire unused_ok = wr_want;
endmodule : pcics_gate

// ### core/pcics_top.sv
// pcics_top: pci configuration command and status registers with gating.
// assumes a one-cycle strobe register port and synchronous inputs.
// Operation
// - MWI disabled: plain memory writes only
// - MWI enabled: invalidate command allowed
// - special cycle bit zero: ignore them
// - special cycle bit one: monitor them
// - bus master zero: never initiate
// - bus master one: may request bus
// - memory claims only when enabled
// - io claims only when enabled
// - reset clears all five enables
// - status 16 bits, read only
// - status resets to 0210h
// - devsel timing reads medium, 01b
// - capability bit means pointer at 34h
`timescale 1ns/1ns
module pcics_top (
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic [9:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic MEM_HIT,
    input wire logic IO_HIT,
    input wire logic SPC_SEEN,
    input wire logic XFER_WANT,
    input wire logic INV_WANT,
    input wire logic XFER_DONE,
    input wire logic GNT,
    output logic REQ,
    output logic MASTER_ON,
    output logic [3:0] MASTER_CMD,
    output logic MEM_CLAIM,
    output logic IO_CLAIM,
    output logic SPC_TAKE,
    output logic IRQ
);
    pcics_if en_if ();

    // register map on the byte-addressed port (index times four)
    //   010h  command enables, bits 4:0 writable, rest read zero
    //   018h  status image, constant, writes dropped
    //   0D0h  capability pointer, constant
    //   100h  event flags, write one to clear
    //   104h  event mask, same layout as the flags
    // the port never stalls: a read answers in the next cycle and the
    // answer is gone one cycle later, so software must sample it then
    //
    // event bits
    //   0  special cycle taken
    //   1  memory claim
    //   2  io claim
    //   3  cycle spent owning the bus with the invalidate command
    //
    // the status image carries no live event bits; parity and abort
    // reporting are left to whichever block sees those conditions
    //
    // the master sequencer runs idle, request, own; it leaves request
    // when bus mastering is switched off, but a transfer that already
    // owns the bus runs to its end, since cutting it would strand the bus
    // the command is frozen at grant for the same reason

    // all state except the sticky event flags in one record
    typedef struct packed {
        logic [4:0] cmd; // command enables
        logic [31:0] rdata; // read answer
        logic [3:0] mask; // event mask
        pcics_pkg::pcics_mst_type mst; // master sequencer
        logic req;
        logic mon;
        logic [3:0] mcmd;
        logic mclaim;
        logic iclaim;
        logic stake;
        logic irq;
    } pcics_st_type;
    pcics_st_type st_r, st_nxt;
    logic mem_c, io_c, spc_c; // qualified claims
    logic [3:0] wcmd; // qualified write command
    logic [3:0] ev_flag; // sticky event bits
    logic [3:0] ev_set; // event pulses
    logic ev_clr_wr; // write to event flags
    logic [15:0] sts; // status image
    assign en_if.cmd = st_r.cmd;

    // qualification is combinational; its results are registered here
    pcics_gate u_gate (
        .clk(REF_CLK),
        .nrst(NRST),
        .en(en_if),
        .mem_hit(MEM_HIT),
        .io_hit(IO_HIT),
        .spc_seen(SPC_SEEN),
        .wr_want(XFER_WANT),
        .wr_inv_want(INV_WANT),
        .mem_claim(mem_c),
        .io_claim(io_c),
        .spc_take(spc_c),
        .wr_cmd(wcmd)
    );

    // a flag set and cleared in one cycle stays set
    // events: special cycles taken, claims taken and invalidate commands issued
    assign ev_set = {st_r.mst == pcics_pkg::PCICS_OWN && st_r.mcmd == pcics_pkg::PCI_MEM_WRITE_INV,
                     io_c, mem_c, spc_c};
    assign ev_clr_wr = WR && ADDR == pcics_pkg::IRQ_STAT_ADDR;

    // one sticky flag per event
    genvar g;
    generate
        for (g = 0; g < pcics_pkg::EV_W; g++) begin : g_ev
            pcics_event u_ev (
                .clk(REF_CLK),
                .nrst(NRST),
                .set(ev_set[g]),
                .clr(ev_clr_wr & WDATA[g]),
                .flag(ev_flag[g])
            );
        end
    endgenerate

    // no write path exists, so no decode slip can load it
    // status image is constant; bus writes never reach it
    assign sts = pcics_pkg::STS_RESET;

    // flag reads see the value before this cycle's events
    // next-state logic: registers, master sequencer, output staging
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 32'h0000_0000;
        if (WR) begin
            case (ADDR)
                pcics_pkg::CMD_ADDR: st_nxt.cmd = WDATA[4:0] & pcics_pkg::CMD_WMASK;
                pcics_pkg::IRQ_MASK_ADDR: st_nxt.mask = WDATA[3:0];
                default: st_nxt.cmd = st_r.cmd; // status and unmapped ignore writes
            endcase
        end
        if (RD) begin
            case (ADDR)
                pcics_pkg::CMD_ADDR: st_nxt.rdata = {27'h0, st_r.cmd};
                pcics_pkg::STS_ADDR: st_nxt.rdata = {16'h0, sts};
                pcics_pkg::CAP_ADDR: st_nxt.rdata = {24'h0, pcics_pkg::CAP_PTR_VALUE};
                pcics_pkg::IRQ_STAT_ADDR: st_nxt.rdata = {28'h0, ev_flag};
                pcics_pkg::IRQ_MASK_ADDR: st_nxt.rdata = {28'h0, st_r.mask};
                default: st_nxt.rdata = 32'h0000_0000; // unmapped reads zero
            endcase
        end

        // bus mastering: request only while enabled; drop on disable
        case (st_r.mst)
            pcics_pkg::PCICS_IDLE: begin
                if (XFER_WANT && st_r.cmd[pcics_pkg::CMD_BM_BIT]) st_nxt.mst = pcics_pkg::PCICS_REQ;
            end
            pcics_pkg::PCICS_REQ: begin
                if (!st_r.cmd[pcics_pkg::CMD_BM_BIT]) st_nxt.mst = pcics_pkg::PCICS_IDLE;
                else if (GNT) st_nxt.mst = pcics_pkg::PCICS_OWN;
            end
            pcics_pkg::PCICS_OWN: begin
                // a transfer in flight ends normally; the next one needs enable again
                if (XFER_DONE) st_nxt.mst = pcics_pkg::PCICS_IDLE;
            end
            default: st_nxt.mst = pcics_pkg::PCICS_IDLE;
        endcase
        st_nxt.req = st_nxt.mst == pcics_pkg::PCICS_REQ;
        st_nxt.mon = st_nxt.mst == pcics_pkg::PCICS_OWN;
        // command latched at grant so it cannot change mid transfer
        if (st_r.mst == pcics_pkg::PCICS_REQ && st_nxt.mst == pcics_pkg::PCICS_OWN) st_nxt.mcmd = wcmd;
        st_nxt.mclaim = mem_c;
        st_nxt.iclaim = io_c;
        st_nxt.stake = spc_c;
        st_nxt.irq = |(ev_flag & st_r.mask);
    end

    // every output below comes straight from this register
    // single register for all state but the event flags; reset clears every enable
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            st_r <= '0;
            st_r.cmd <= pcics_pkg::CMD_RESET;
            st_r.mst <= pcics_pkg::PCICS_IDLE;
            st_r.mcmd <= pcics_pkg::PCI_MEM_WRITE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs taken straight from state
    assign RDATA = st_r.rdata;
    assign REQ = st_r.req;
    assign MASTER_ON = st_r.mon;
    assign MASTER_CMD = st_r.mcmd;
    assign MEM_CLAIM = st_r.mclaim;
    assign IO_CLAIM = st_r.iclaim;
    assign SPC_TAKE = st_r.stake;
    assign IRQ = st_r.irq;

    // assertions
    sequence s_cmd_wr;
        WR && ADDR == pcics_pkg::CMD_ADDR;
    endsequence
    sequence s_cmd_rd;
        RD && ADDR == pcics_pkg::CMD_ADDR;
    endsequence

    // grant seen while requesting with bus mastering still on
    sequence s_grant;
        st_r.mst == pcics_pkg::PCICS_REQ && GNT && st_r.cmd[pcics_pkg::CMD_BM_BIT];
    endsequence

    // invalidate wanted and allowed
    sequence s_mwi_ok;
        INV_WANT && st_r.cmd[pcics_pkg::CMD_MWI_BIT];
    endsequence
    cmd_roundtrip_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        s_cmd_wr ##1 s_cmd_rd |=> RDATA[4:0] == $past(WDATA[4:0], 2))
        else $error("command readback mismatch");
    req_needs_bm_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        REQ |-> $past(st_r.cmd[pcics_pkg::CMD_BM_BIT]))
        else $error("request without bus master enable");
    req_rises_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        st_r.mst == pcics_pkg::PCICS_IDLE && XFER_WANT && st_r.cmd[pcics_pkg::CMD_BM_BIT] |=> REQ)
        else $error("request not raised");
    sts_read_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        RD && ADDR == pcics_pkg::STS_ADDR |=> RDATA == 32'h0000_0210)
        else $error("status value wrong");
    devsel_med_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        RD && ADDR == pcics_pkg::STS_ADDR |=> RDATA[10:9] == pcics_pkg::DEVSEL_MEDIUM)
        else $error("devsel timing wrong");
    sts_ro_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        WR && ADDR == pcics_pkg::STS_ADDR ##1 RD && ADDR == pcics_pkg::STS_ADDR |=> RDATA[15:0] == 16'h0210)
        else $error("status took a write");
    mem_claim_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        MEM_HIT && !st_r.cmd[pcics_pkg::CMD_MEM_BIT] |=> !MEM_CLAIM)
        else $error("memory claimed while disabled");
    spc_take_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        SPC_SEEN && st_r.cmd[pcics_pkg::CMD_SPC_BIT] |=> SPC_TAKE)
        else $error("special cycle missed");
    reset_clear_a: assert property (@(posedge REF_CLK) $rose(NRST) |-> st_r.cmd == 5'h00)
        else $error("enables not cleared by reset");

    // read data last one cycle and the port rests at zero
    rdata_idle_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        !RD |=> RDATA == 32'h0000_0000)
        else $error("read data lingered");

    // enables change only by a command write
    cmd_hold_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        !(WR && ADDR == pcics_pkg::CMD_ADDR) |=> $stable(st_r.cmd))
        else $error("enables changed without a write");

    // a command write lands in the next cycle
    cmd_write_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        WR && ADDR == pcics_pkg::CMD_ADDR |=> st_r.cmd == $past(WDATA[4:0]))
        else $error("command write lost");

    // grant moves the sequencer to ownership
    mon_on_grant_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        s_grant |=> MASTER_ON && !REQ)
        else $error("ownership not taken at grant");

    // plain write latched when invalidate is off
    cmd_plain_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        s_grant ##0 !st_r.cmd[pcics_pkg::CMD_MWI_BIT] |=> MASTER_CMD == pcics_pkg::PCI_MEM_WRITE)
        else $error("plain write not latched");

    // invalidate latched when wanted and allowed
    cmd_inv_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        s_grant ##0 s_mwi_ok |=> MASTER_CMD == pcics_pkg::PCI_MEM_WRITE_INV)
        else $error("invalidate not latched");

    // command frozen while owning
    mcmd_stable_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        MASTER_ON && $past(MASTER_ON) |-> $stable(MASTER_CMD))
        else $error("command changed mid transfer");

    // done pulse ends ownership
    owner_ends_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        MASTER_ON && XFER_DONE |=> !MASTER_ON)
        else $error("ownership outlived done");

    // request withdrawn once bus mastering is off
    req_drop_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        REQ && !st_r.cmd[pcics_pkg::CMD_BM_BIT] |=> !REQ)
        else $error("request kept while disabled");

    // idle with bus mastering off never requests
    req_idle_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        st_r.mst == pcics_pkg::PCICS_IDLE && !st_r.cmd[pcics_pkg::CMD_BM_BIT] |=> !REQ)
        else $error("request from idle while disabled");

    // request and ownership never together
    req_mon_excl_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        !(REQ && MASTER_ON))
        else $error("request while owning");

    // ownership only follows a grant
    mon_needs_gnt_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        $rose(MASTER_ON) |-> $past(GNT))
        else $error("ownership without grant");

    // memory hit claimed when enabled
    mem_take_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        MEM_HIT && st_r.cmd[pcics_pkg::CMD_MEM_BIT] |=> MEM_CLAIM)
        else $error("memory hit not claimed");

    // io hit ignored when disabled
    io_claim_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        IO_HIT && !st_r.cmd[pcics_pkg::CMD_IO_BIT] |=> !IO_CLAIM)
        else $error("io claimed while disabled");

    // io hit claimed when enabled
    io_take_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        IO_HIT && st_r.cmd[pcics_pkg::CMD_IO_BIT] |=> IO_CLAIM)
        else $error("io hit not claimed");

    // special cycles ignored when disabled
    spc_ignore_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        !st_r.cmd[pcics_pkg::CMD_SPC_BIT] |=> !SPC_TAKE)
        else $error("special cycle taken while disabled");

    // capability pointer reads its constant
    cap_ptr_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        RD && ADDR == pcics_pkg::CAP_ADDR |=> RDATA == {24'h0, pcics_pkg::CAP_PTR_VALUE})
        else $error("capability pointer wrong");

    // interrupt follows unmasked flags
    irq_set_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        |(ev_flag & st_r.mask) |=> IRQ)
        else $error("interrupt missing");

    // interrupt drops with no unmasked flag
    irq_clear_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        !(|(ev_flag & st_r.mask)) |=> !IRQ)
        else $error("interrupt stuck");

    // mask write lands in the next cycle
    mask_write_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        WR && ADDR == pcics_pkg::IRQ_MASK_ADDR |=> st_r.mask == $past(WDATA[3:0]))
        else $error("mask write lost");

    // flag read returns the flags of the read cycle
    flags_rd_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        RD && ADDR == pcics_pkg::IRQ_STAT_ADDR |=> RDATA[3:0] == $past(ev_flag))
        else $error("flag read wrong");
endmodule : pcics_top

// ### verif/pci_cfg_command_status_bench.sv
// bench for pcics_top: register port, target decode, master and events.
// assumes the host model below owns GNT and XFER_DONE.
`timescale 1ns/1ns
module pci_cfg_command_status_bench;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
    logic mem_hit = 1'b0, io_hit = 1'b0, spc_seen = 1'b0;
    logic xfer_want = 1'b0, inv_want = 1'b0, gnt, done;
    logic [9:0] addr = 10'h000;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic req, master_on, mem_claim, io_claim, spc_take, irq;
    logic [3:0] master_cmd;
    int mismatches = 0, checks = 0;
    pcics_top pcics_top_inst (.REF_CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .MEM_HIT(mem_hit), .IO_HIT(io_hit), .SPC_SEEN(spc_seen), .XFER_WANT(xfer_want),
        .INV_WANT(inv_want), .XFER_DONE(done), .GNT(gnt), .REQ(req), .MASTER_ON(master_on),
        .MASTER_CMD(master_cmd), .MEM_CLAIM(mem_claim), .IO_CLAIM(io_claim), .SPC_TAKE(spc_take), .IRQ(irq));
    pcics_host_model pcics_host_model_inst (.clk(clk), .nrst(nrst), .req(req), .owning(master_on),
        .gnt(gnt), .done(done));
    // 250 MHz reference clock
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // one-cycle write strobe
    task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [9:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    // bounded wait on REQ (sel 0) or MASTER_ON (sel 1)
    task automatic wait_lvl(input int sel, input logic lvl);
        int n;
        n = 0;
        while (n < 60 && (sel ? master_on : req) !== lvl) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 60) begin
            mismatches++;
            $display("Error at %0t: master handshake hung", $time);
            give_verdict();
        end
    endtask : wait_lvl
    task automatic t_reset;
        rd_reg(pcics_pkg::CMD_ADDR, v);
        chk(v, 32'h0000_0000);
        rd_reg(pcics_pkg::STS_ADDR, v);
        chk(v, 32'h0000_0210);
        chk(v[10:9], 2'h1);
        rd_reg(pcics_pkg::CAP_ADDR, v);
        chk(v, {24'h0, pcics_pkg::CAP_PTR_VALUE});
        $display("test reset values finished");
    endtask : t_reset
    task automatic t_regs;
        wr_reg(pcics_pkg::CMD_ADDR, 32'h0000_001F);
        rd_reg(pcics_pkg::CMD_ADDR, v);
        chk(v, 32'h0000_001F);
        wr_reg(pcics_pkg::CMD_ADDR, 32'h0000_000A);
        wr_reg(pcics_pkg::STS_ADDR, 32'hFFFF_FFFF);
        rd_reg(pcics_pkg::CMD_ADDR, v);
        chk(v, 32'h0000_000A);
        rd_reg(pcics_pkg::STS_ADDR, v);
        chk(v, 32'h0000_0210);
        rd_reg(10'h3FC, v);
        chk(v, 32'h0000_0000);
        $display("test register access finished");
    endtask : t_regs
    // each decode kind off, then on, with its hit held
    task automatic t_decode;
        logic [7:0] en_tab [3] = '{8'h02, 8'h01, 8'h08};
        for (int k = 0; k < 3; k++) begin
            wr_reg(pcics_pkg::CMD_ADDR, 32'h0);
            {spc_seen, io_hit, mem_hit} <= 3'h1 << k;
            cyc(3);
            chk({spc_take, io_claim, mem_claim}, 3'h0);
            wr_reg(pcics_pkg::CMD_ADDR, {24'h0, en_tab[k]});
            cyc(2);
            chk({spc_take, io_claim, mem_claim}, 3'h1 << k);
            {spc_seen, io_hit, mem_hit} <= 3'h0;
        end
        $display("test target decode finished");
    endtask : t_decode
    task automatic t_master;
        wr_reg(pcics_pkg::CMD_ADDR, 32'h0000_0010);
        xfer_want <= 1'b1;
        inv_want <= 1'b1;
        repeat (20) begin
            cyc(1);
            chk({req, master_on}, 2'h0);
        end
        for (int m = 0; m < 2; m++) begin
            wr_reg(pcics_pkg::CMD_ADDR, m ? 32'h0000_0014 : 32'h0000_0004);
            xfer_want <= 1'b1;
            wait_lvl(0, 1'b1);
            chk(req, 1'b1);
            wait_lvl(1, 1'b1);
            chk(master_cmd, m ? 4'hF : 4'h7);
            xfer_want <= 1'b0;
            wait_lvl(1, 1'b0);
        end
        $display("test bus master finished");
    endtask : t_master
    task automatic t_irq;
        wr_reg(pcics_pkg::IRQ_STAT_ADDR, 32'h0000_000F);
        wr_reg(pcics_pkg::IRQ_MASK_ADDR, 32'h0);
        wr_reg(pcics_pkg::CMD_ADDR, 32'h0000_0002);
        mem_hit <= 1'b1;
        @(posedge clk);
        mem_hit <= 1'b0;
        cyc(3);
        rd_reg(pcics_pkg::IRQ_STAT_ADDR, v);
        chk(v, 32'h0000_0002);
        chk(irq, 1'b0);
        wr_reg(pcics_pkg::IRQ_MASK_ADDR, 32'h0000_0002);
        cyc(2);
        chk(irq, 1'b1);
        wr_reg(pcics_pkg::IRQ_STAT_ADDR, 32'h0000_0002);
        cyc(2);
        chk(irq, 1'b0);
        $display("test interrupt finished");
    endtask : t_irq
    // reset in mid-run must drop every enable again
    task automatic t_rerst;
        wr_reg(pcics_pkg::CMD_ADDR, 32'h0000_001F);
        nrst <= 1'b0;
        cyc(2);
        nrst <= 1'b1;
        rd_reg(pcics_pkg::CMD_ADDR, v);
        chk(v, 32'h0000_0000);
        $display("test second reset finished");
    endtask : t_rerst
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_regs();
        t_decode();
        t_master();
        t_irq();
        t_rerst();
        give_verdict();
    end
endmodule : pci_cfg_command_status_bench

// ### verif/pcics_host_model.sv
// pcics_host_model: arbiter stand-in on the far side of the master port.
// assumes REQ and MASTER_ON are registered outputs on the same clock.
`timescale 1ns/1ns
module pcics_host_model #(
    parameter int GNT_DELAY = 3, // arbitration latency in cycles
    parameter int XFER_LEN = 4 // cycles a transfer lasts
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic req,
    input wire logic owning,
    output logic gnt,
    output logic done
);
    int wait_r; // cycles since request or since ownership began
    // grant after the latency, end ownership with a one-cycle done pulse
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gnt <= 1'b0;
            done <= 1'b0;
            wait_r <= 0;
        end else begin
            done <= 1'b0;
            if (owning && !done) begin
                wait_r <= wait_r + 1;
                if (wait_r == XFER_LEN) begin
                    done <= 1'b1;
                    gnt <= 1'b0;
                    wait_r <= 0;
                end
            end else if (req && !gnt) begin
                wait_r <= wait_r + 1;
                if (wait_r == GNT_DELAY) begin
                    gnt <= 1'b1;
                    wait_r <= 0;
                end
            end else if (!req && !owning) begin
                // request withdrawn: a grant never lingers on an idle bus
                gnt <= 1'b0;
                wait_r <= 0;
            end
        end
    end
endmodule : pcics_host_model
